// ---- hdl/opvs_device.sv ----
// device end: one-pin voltage-set receiver with mode selection
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module opvs_device #(
   parameter int TIMEOUT_CYC = opvs_pkg::TIMEOUT_CYC,
   parameter int ACK_PULSE_CYC = opvs_pkg::ACK_PULSE_CYC,
   parameter logic [7:0] DEV_ADDR = opvs_pkg::DEV_ADDR
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CE_I,
   input wire logic CONV_ONE_ENABLE_I,
   input wire logic CONV_TWO_ENABLE_I,
   opvs_if.device LINK,
   output logic [4:0] CONV1_VOLTAGE_SETTING_O,
   output logic [4:0] CONV2_VOLTAGE_SETTING_O,
   output logic FORCED_PWM_O,
   output logic RX_READY_O,
   output logic FRAME_OK_O
);
   // ****************************************
   // states and storage
   // ****************************************
   typedef enum logic [2:0] {
      D_OFF = 3'h0,
      D_IDLE = 3'h1,
      D_RX = 3'h2,
      D_ACKW = 3'h3,
      D_ACK = 3'h4
   } opvs_dstate_t;

   localparam int CW = opvs_pkg::CNT_W;

   opvs_dstate_t st_q;
   logic [CW-1:0] cnt_q;
   logic line_q;
   logic run_q;
   logic [3:0] bits_q;
   logic [15:0] sr_q;
   logic err_q;
   logic pwm_q;
   logic ready_q;
   logic ok_q;
   logic oe_n_q;
   logic do_q;
   logic [4:0] set1_q;
   logic [4:0] set2_q;

   // ****************************************
   // decoding
   // ****************************************
   wire line = LINK.line;
   wire active = CONV_ONE_ENABLE_I || CONV_TWO_ENABLE_I;
   wire fall = line_q && !line;
   wire hold = (st_q == D_ACKW) || (st_q == D_ACK);
   wire bit_done;
   wire bit_val;
   wire bit_bad;
   wire tout;
   wire [15:0] word = {sr_q[14:0], bit_val};
   wire byte_last = bit_done && (bits_q[2:0] == 3'h7);
   wire frame_last = bit_done && (bits_q == 4'hf);
   wire err_all = err_q || bit_bad;
   wire addr_hit = word[15:8] == DEV_ADDR;
   wire [1:0] sel = word[opvs_pkg::SEL_HI:opvs_pkg::SEL_LO];
   wire ack_req = word[opvs_pkg::ACK_REQ_BIT];
   wire frame_good = frame_last && !err_all && addr_hit;
   wire ack_go = frame_good && ack_req;
   wire load1 = frame_good && (sel == opvs_pkg::SEL_CONV1);
   wire load2 = frame_good && (sel == opvs_pkg::SEL_CONV2);
   wire start_end = cnt_q == CW'(opvs_pkg::STARTUP_CYC - 1);
   wire delay_end = cnt_q == CW'(opvs_pkg::ACK_DELAY_CYC - 1);
   wire pulse_end = cnt_q == CW'(ACK_PULSE_CYC - 1);

   assign CONV1_VOLTAGE_SETTING_O = set1_q;
   assign CONV2_VOLTAGE_SETTING_O = set2_q;
   assign FORCED_PWM_O = pwm_q;
   assign RX_READY_O = ready_q;
   assign FRAME_OK_O = ok_q;
   assign LINK.dev_do = do_q;
   assign LINK.dev_oe_n = oe_n_q;

   // ****************************************
   // bit meter
   // ****************************************
   // the meter decodes from each bit's own ratio, so no rate is preset
   opvs_bit_meas #(
      .CNT_W(CW),
      .TIMEOUT_CYC(TIMEOUT_CYC)
   ) i_opvs_bit_meas (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .ce_i(CE_I),
      .line_i(line),
      .fall_i(fall),
      .run_i(run_q),
      .hold_i(hold),
      .done_o(bit_done),
      .val_o(bit_val),
      .bad_o(bit_bad),
      .tout_o(tout)
   );

   // ****************************************
   // settings and mode
   // ****************************************
   // settings survive converter disable, only reset clears them
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         set1_q <= opvs_pkg::SETTING_RST;
         set2_q <= opvs_pkg::SETTING_RST;
         pwm_q <= 1'b0;
         ok_q <= 1'b0;
         line_q <= 1'b1;
         do_q <= 1'b0;
      end else if (CE_I) begin
         line_q <= line;
         ok_q <= frame_good;
         if (load1) begin
            set1_q <= word[opvs_pkg::SET_W-1:0];
         end
         if (load2) begin
            set2_q <= word[opvs_pkg::SET_W-1:0];
         end
         if (!active) begin
            pwm_q <= 1'b0;
         end else if (line) begin
            pwm_q <= 1'b1;
         end else if (tout) begin
            pwm_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // receive sequencer
   // ****************************************
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         st_q <= D_OFF;
         cnt_q <= '0;
         run_q <= 1'b0;
         bits_q <= 4'h0;
         sr_q <= 16'h0000;
         err_q <= 1'b0;
         ready_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else if (CE_I) begin
         if (!active) begin
            st_q <= D_OFF;
            cnt_q <= '0;
            run_q <= 1'b0;
            ready_q <= 1'b0;
            oe_n_q <= 1'b1;
         end else begin
            unique case (st_q)
               D_OFF: begin
                  cnt_q <= cnt_q + 1'b1;
                  if (start_end) begin
                     st_q <= D_IDLE;
                     cnt_q <= '0;
                     ready_q <= 1'b1;
                  end
               end
               D_IDLE: begin
                  if (fall) begin
                     st_q <= D_RX;
                     run_q <= 1'b1;
                     bits_q <= 4'h0;
                     err_q <= 1'b0;
                  end
               end
               D_RX: begin
                  if (tout) begin
                     st_q <= D_IDLE;
                     run_q <= 1'b0;
                  end else if (bit_done) begin
                     sr_q <= word;
                     bits_q <= bits_q + 1'b1;
                     err_q <= err_all;
                     if (byte_last) begin
                        run_q <= 1'b0;
                     end
                     if (frame_last) begin
                        st_q <= ack_go ? D_ACKW : D_IDLE;
                        cnt_q <= '0;
                     end
                  end else if (fall) begin
                     run_q <= 1'b1;
                  end
               end
               D_ACKW: begin
                  cnt_q <= cnt_q + 1'b1;
                  if (delay_end) begin
                     st_q <= D_ACK;
                     cnt_q <= '0;
                     oe_n_q <= 1'b0;
                  end
               end
               D_ACK: begin
                  cnt_q <= cnt_q + 1'b1;
                  if (pulse_end) begin
                     st_q <= D_IDLE;
                     cnt_q <= '0;
                     oe_n_q <= 1'b1;
                  end
               end
               default: begin
                  st_q <= D_OFF;
               end
            endcase
         end
      end
   end
endmodule

// ---- hdl/opvs_pkg.sv ----
// shared constants for the one-pin voltage-set link
package opvs_pkg;
   // ****************************************
   // clock and line timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int STARTUP_US = 170;
   localparam int TIMEOUT_US = 520;
   localparam int ACK_PULSE_US = 520;
   localparam int ACK_DELAY_US = 10;
   localparam int STREAM_END_US = 4;
   localparam int START_US = 4;
   // least times round up, longest times round down
   localparam int STARTUP_CYC = (STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMEOUT_CYC = (TIMEOUT_US * 1000) / CLK_PERIOD_NS;
   localparam int ACK_PULSE_CYC = (ACK_PULSE_US * 1000) / CLK_PERIOD_NS;
   localparam int ACK_DELAY_CYC = (ACK_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STREAM_END_CYC = (STREAM_END_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int START_CYC = (START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_MARGIN_CYC = 4;
   localparam int ACK_SAMPLE_CYC = 2;
   localparam int LONG_UNITS = 3;
   localparam int CNT_W = 16;
   // ****************************************
   // frame layout
   // ****************************************
   // arbitrary address value
   localparam logic [7:0] DEV_ADDR = 8'ha5;
   localparam int ACK_REQ_BIT = 7;
   localparam int SEL_HI = 6;
   localparam int SEL_LO = 5;
   localparam int SET_W = 5;
   localparam logic [1:0] SEL_CONV1 = 2'h0;
   localparam logic [1:0] SEL_CONV2 = 2'h2;
   localparam logic [4:0] SETTING_RST = 5'h00;
   // ****************************************
   // host register map
   // ****************************************
   localparam logic [3:0] REG_DATA = 4'h0;
   localparam logic [3:0] REG_MODE = 4'h4;
   localparam logic [3:0] REG_STAT = 4'h8;
   localparam logic [3:0] REG_UNIT = 4'hc;
   localparam int STAT_BUSY = 0;
   localparam int STAT_ACK = 1;
   localparam int STAT_DONE = 2;
   localparam logic MODE_RST = 1'b0;
   localparam logic [15:0] UNIT_RST = 16'h0010;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- hdl/opvs_if.sv ----
// single-wire link between host and device, open drain with pull-up
`timescale 1ns/1ps
interface opvs_if;
   logic line;
   logic host_do;
   logic host_oe_n;
   logic dev_do;
   logic dev_oe_n;
   // pull-up wins unless an enabled driver pulls low
   assign line = !((!host_oe_n && !host_do) || (!dev_oe_n && !dev_do));
   modport device(input line, output dev_do, output dev_oe_n);
   modport host(input line, output host_do, output host_oe_n);
endinterface

// ---- hdl/opvs_bit_meas.sv ----
// low/high time meter for one bit and low-level timeout
`timescale 1ns/1ps
module opvs_bit_meas #(
   parameter int CNT_W = opvs_pkg::CNT_W,
   parameter int TIMEOUT_CYC = opvs_pkg::TIMEOUT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic line_i,
   input wire logic fall_i,
   input wire logic run_i,
   input wire logic hold_i,
   output logic done_o,
   output logic val_o,
   output logic bad_o,
   output logic tout_o
);
   logic [CNT_W-1:0] low_q;
   logic [CNT_W-1:0] high_q;
   logic [CNT_W-1:0] lrun_q;
   wire [CNT_W:0] low2 = {low_q, 1'b0};
   wire [CNT_W:0] high2 = {high_q, 1'b0};
   wire [CNT_W:0] high_x = {1'b0, high_q};
   wire [CNT_W:0] low_x = {1'b0, low_q};
   wire is_one = high_x >= low2;
   wire is_zero = low_x >= high2;
   wire low_sat = &low_q;
   wire high_sat = &high_q;
   wire lrun_sat = &lrun_q;

   assign done_o = fall_i && run_i;
   assign val_o = is_one && !is_zero;
   assign bad_o = is_one == is_zero;
   assign tout_o = !line_i && !hold_i && (lrun_q == CNT_W'(TIMEOUT_CYC - 1));

   // ****************************************
   // bit counters, restarted by each falling edge; low-run counter cleared while high or held
   // ****************************************
   // saturation keeps a long forced-pwm high from wrapping to a short one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         low_q <= '0;
         high_q <= '0;
         lrun_q <= '0;
      end else if (ce_i) begin
         if (fall_i) begin
            low_q <= '0;
            high_q <= '0;
         end else if (!line_i && !low_sat) begin
            low_q <= low_q + 1'b1;
         end else if (line_i && !high_sat) begin
            high_q <= high_q + 1'b1;
         end
         if (line_i || hold_i) begin
            lrun_q <= '0;
         end else if (!lrun_sat) begin
            lrun_q <= lrun_q + 1'b1;
         end
      end
   end
endmodule

// ---- hdl/opvs_host.sv ----
// host end: sends voltage-set frames, controlled over AXI4-Lite
`timescale 1ns/1ps
module opvs_host #(
   parameter logic [7:0] DEV_ADDR = opvs_pkg::DEV_ADDR
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic CE_I,
   opvs_if.host LINK,
   input wire logic [3:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [3:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I
);
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_START = 3'h1,
      H_LOW = 3'h2,
      H_HIGH = 3'h3,
      H_SEND_END = 3'h4,
      H_ACKREL = 3'h5,
      H_WAITHI = 3'h6
   } opvs_hstate_t;

   function automatic logic reg_hit(input logic [3:0] a);
      reg_hit = (a == opvs_pkg::REG_DATA) || (a == opvs_pkg::REG_MODE) ||
                (a == opvs_pkg::REG_STAT) || (a == opvs_pkg::REG_UNIT);
   endfunction

   opvs_hstate_t st_q;
   logic [17:0] cnt_q;
   logic [3:0] idx_q;
   logic [15:0] sr_q;
   logic [7:0] data_q;
   logic mode_q, busy_q, ack_q, done_q, oe_n_q, do_q;
   logic [15:0] unit_q;
   logic awr_q, bv_q, arr_q, rv_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;

   // ****************************************
   // register decode
   // ****************************************
   wire wr_hs = awr_q && S_AXI_AWVALID_I && S_AXI_WVALID_I;
   wire rd_hs = arr_q && S_AXI_ARVALID_I;
   wire w_hit = reg_hit(S_AXI_AWADDR_I);
   wire w_data = wr_hs && (S_AXI_AWADDR_I == opvs_pkg::REG_DATA) && S_AXI_WSTRB_I[0];
   wire go = w_data && !busy_q;
   wire w_err = !w_hit || (w_data && busy_q);
   wire [15:0] w_unit = (S_AXI_WDATA_I[15:0] == 16'h0000) ? 16'h0001 : S_AXI_WDATA_I[15:0];
   wire [2:0] stat = {done_q, ack_q, busy_q};
   wire [31:0] rd_word = (S_AXI_ARADDR_I == opvs_pkg::REG_DATA) ? {24'h0, data_q} :
                         (S_AXI_ARADDR_I == opvs_pkg::REG_MODE) ? {31'h0, mode_q} :
                         (S_AXI_ARADDR_I == opvs_pkg::REG_STAT) ? {29'h0, stat} :
                         (S_AXI_ARADDR_I == opvs_pkg::REG_UNIT) ? {16'h0, unit_q} : 32'h0;

   // ****************************************
   // line timing
   // ****************************************
   wire line = LINK.line;
   wire [17:0] u_short = {2'h0, unit_q};
   wire [17:0] u_long = 18'(unit_q * opvs_pkg::LONG_UNITS);
   wire one = sr_q[15];
   wire ack_req = data_q[opvs_pkg::ACK_REQ_BIT];
   wire first_byte = idx_q == 4'h8;
   wire [17:0] end_lim = (!first_byte && ack_req) ?
                         18'(opvs_pkg::ACK_DELAY_CYC + opvs_pkg::ACK_MARGIN_CYC) :
                         18'(opvs_pkg::STREAM_END_CYC);
   wire [17:0] lim = (st_q == H_START) ? 18'(opvs_pkg::START_CYC) :
                     (st_q == H_LOW) ? (one ? u_short : u_long) :
                     (st_q == H_HIGH) ? (one ? u_long : u_short) :
                     (st_q == H_SEND_END) ? end_lim : 18'(opvs_pkg::ACK_SAMPLE_CYC);
   wire tick_end = cnt_q == lim - 18'h1;

   assign LINK.host_do = do_q;
   assign LINK.host_oe_n = oe_n_q;
   assign S_AXI_AWREADY_O = awr_q;
   assign S_AXI_WREADY_O = awr_q;
   assign S_AXI_BVALID_O = bv_q;
   assign S_AXI_BRESP_O = bresp_q;
   assign S_AXI_ARREADY_O = arr_q;
   assign S_AXI_RVALID_O = rv_q;
   assign S_AXI_RRESP_O = rresp_q;
   assign S_AXI_RDATA_O = rdata_q;

   // ****************************************
   // AXI4-Lite slave
   // ****************************************
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         {awr_q, bv_q, arr_q, rv_q} <= 4'h0;
         bresp_q <= opvs_pkg::RESP_OKAY;
         rresp_q <= opvs_pkg::RESP_OKAY;
         rdata_q <= 32'h0;
         mode_q <= opvs_pkg::MODE_RST;
         unit_q <= opvs_pkg::UNIT_RST;
         data_q <= 8'h00;
      end else if (CE_I) begin
         awr_q <= S_AXI_AWVALID_I && S_AXI_WVALID_I && !awr_q && !bv_q;
         arr_q <= S_AXI_ARVALID_I && !arr_q && !rv_q;
         if (wr_hs) begin
            bv_q <= 1'b1;
            bresp_q <= w_err ? opvs_pkg::RESP_SLVERR : opvs_pkg::RESP_OKAY;
         end else if (S_AXI_BREADY_I) begin
            bv_q <= 1'b0;
         end
         if (rd_hs) begin
            rv_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= reg_hit(S_AXI_ARADDR_I) ? opvs_pkg::RESP_OKAY : opvs_pkg::RESP_SLVERR;
         end else if (S_AXI_RREADY_I) begin
            rv_q <= 1'b0;
         end
         if (go) begin
            data_q <= S_AXI_WDATA_I[7:0];
         end
         if (wr_hs && (S_AXI_AWADDR_I == opvs_pkg::REG_MODE) && S_AXI_WSTRB_I[0]) begin
            mode_q <= S_AXI_WDATA_I[0];
         end
         if (wr_hs && (S_AXI_AWADDR_I == opvs_pkg::REG_UNIT) && (&S_AXI_WSTRB_I[1:0])) begin
            unit_q <= w_unit;
         end
      end
   end

   // ****************************************
   // frame sender
   // ****************************************
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         st_q <= H_IDLE;
         cnt_q <= 18'h0;
         idx_q <= 4'h0;
         sr_q <= 16'h0;
         {busy_q, ack_q, done_q, do_q} <= 4'h0;
         oe_n_q <= 1'b1;
      end else if (CE_I) begin
         cnt_q <= tick_end ? 18'h0 : cnt_q + 18'h1;
         unique case (st_q)
            H_IDLE: begin
               cnt_q <= 18'h0;
               oe_n_q <= mode_q;
               if (go) begin
                  st_q <= H_START;
                  sr_q <= {DEV_ADDR, S_AXI_WDATA_I[7:0]};
                  idx_q <= 4'h0;
                  {busy_q, ack_q, done_q} <= 3'h4;
                  oe_n_q <= 1'b1;
               end
            end
            H_START: if (tick_end) begin
               st_q <= H_LOW;
               oe_n_q <= 1'b0;
            end
            H_LOW: if (tick_end) begin
               st_q <= H_HIGH;
               oe_n_q <= 1'b1;
            end
            H_HIGH: if (tick_end) begin
               sr_q <= {sr_q[14:0], 1'b0};
               idx_q <= idx_q + 4'h1;
               oe_n_q <= 1'b0;
               st_q <= (idx_q[2:0] == 3'h7) ? H_SEND_END : H_LOW;
            end
            H_SEND_END: if (tick_end) begin
               oe_n_q <= 1'b1;
               st_q <= first_byte ? H_START : (ack_req ? H_ACKREL : H_WAITHI);
            end
            H_ACKREL: if (tick_end) begin
               ack_q <= !line;
               st_q <= H_WAITHI;
            end
            H_WAITHI: if (line) begin
               st_q <= H_IDLE;
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
            default: st_q <= H_IDLE;
         endcase
      end
   end
endmodule

// ---- sim/opvs_assertions.sv ----
// wire-level checks on the one-pin link
`timescale 1ns/1ps
module opvs_assertions #(
   parameter int ACK_PULSE_CYC = 300
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire logic line_i,
   input wire logic host_do_i,
   input wire logic host_oe_n_i,
   input wire logic dev_do_i,
   input wire logic dev_oe_n_i
);
   // counters, since long repetitions crawl in the tools
   int lo_n;
   int ak_n;
   always_ff @(posedge CLK_I) begin
      lo_n <= (SYS_RST_I || host_oe_n_i) ? 0 : lo_n + 1;
      ak_n <= (SYS_RST_I || dev_oe_n_i) ? 0 : ak_n + 1;
   end
   // ****
   // properties
   // ****
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   property p_host_od; !host_oe_n_i |-> !host_do_i; endproperty
   a_host_od: assert property (p_host_od) else $error("host drove high");
   property p_dev_od; !dev_oe_n_i |-> !dev_do_i; endproperty
   a_dev_od: assert property (p_dev_od) else $error("device drove high");
   // line must have been low well before the pull-down comes on
   property p_ack_wait; $fell(dev_oe_n_i) |-> !$past(line_i, 90); endproperty
   a_ack_wait: assert property (p_ack_wait) else $error("ack too early");
   property p_ack_hold; $fell(dev_oe_n_i) |-> !$past(host_oe_n_i); endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("host let go early");
   property p_ack_min; $fell(dev_oe_n_i) |=> !dev_oe_n_i [*8]; endproperty
   a_ack_min: assert property (p_ack_min) else $error("ack too short");
   property p_ack_max; ak_n <= ACK_PULSE_CYC; endproperty
   a_ack_max: assert property (p_ack_max) else $error("ack too long");
   property p_quiet; ak_n > 8 |-> host_oe_n_i; endproperty
   a_quiet: assert property (p_quiet) else $error("host active in ack");
   property p_low_min; $rose(host_oe_n_i) |-> lo_n > 12; endproperty
   a_low_min: assert property (p_low_min) else $error("low too short");
   c_ack: cover property ($fell(dev_oe_n_i));
   c_bit: cover property ($rose(host_oe_n_i) && lo_n < 20);
   c_end: cover property ($rose(host_oe_n_i) && lo_n > 100);
endmodule

// ---- sim/one_pin_voltage_set_receiver_tb_top.sv ----
// bench: host and device on one link, bit-banged second link
`timescale 1ns/1ps
module one_pin_voltage_set_receiver_tb_top;
   localparam int TO = 300;
   localparam logic [7:0] ADR = opvs_pkg::DEV_ADDR;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, en1 = 1'b1, enb = 1'b1;
   logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic awr, wrd, bv, arr, rv, pwm, rdy, fok, rdy2, ak;
   logic [3:0] awa = 4'h0, ara = 4'h0;
   logic [31:0] wd = 32'h0, rdd, s;
   logic [1:0] br, rr, sr;
   logic [4:0] c1, c2, c1b, e1, e2;
   logic [7:0] d;
   logic [7:0] fr [6] = '{8'h95, 8'h5f, 8'ha3, 8'he7, 8'hc0, 8'h1f};
   logic [15:0] mon = 16'h0;
   int n_errors = 0, tests_run = 0, oks = 0, lo = 0, u = 16, n, i, pz = 0, pz0;
   opvs_if lk();
   opvs_if lk2();
   opvs_host i_opvs_host (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .LINK(lk.host),
      .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr),
      .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrd),
      .S_AXI_BRESP_O(br), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
      .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
      .S_AXI_RDATA_O(rdd), .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre));
   opvs_device #(.TIMEOUT_CYC(TO), .ACK_PULSE_CYC(TO)) i_opvs_device (.CLK_I(clk),
      .SYS_RST_I(rst), .CE_I(ce), .CONV_ONE_ENABLE_I(en1), .CONV_TWO_ENABLE_I(enb),
      .LINK(lk.device), .CONV1_VOLTAGE_SETTING_O(c1), .CONV2_VOLTAGE_SETTING_O(c2),
      .FORCED_PWM_O(pwm), .RX_READY_O(rdy), .FRAME_OK_O(fok));
   opvs_device #(.TIMEOUT_CYC(TO), .ACK_PULSE_CYC(TO)) i_opvs_device_b (.CLK_I(clk),
      .SYS_RST_I(rst), .CE_I(ce), .CONV_ONE_ENABLE_I(enb), .CONV_TWO_ENABLE_I(enb),
      .LINK(lk2.device), .CONV1_VOLTAGE_SETTING_O(c1b), .CONV2_VOLTAGE_SETTING_O(),
      .FORCED_PWM_O(), .RX_READY_O(rdy2), .FRAME_OK_O());
   opvs_assertions #(.ACK_PULSE_CYC(TO)) i_opvs_assertions (.CLK_I(clk), .SYS_RST_I(rst),
      .line_i(lk.line), .host_do_i(lk.host_do), .host_oe_n_i(lk.host_oe_n),
      .dev_do_i(lk.dev_do), .dev_oe_n_i(lk.dev_oe_n));
   always #50 clk = ~clk;
   // bit decoder on the wire; start, stop and ack lows fall outside both windows
   always @(posedge clk) begin
      if (fok === 1'b1) oks <= oks + 1;
      if (pwm === 1'b0) pz <= pz + 1;
      lo <= (lk.line === 1'b0) ? lo + 1 : 0;
      if (lk.line === 1'b1 && lo > u - 3 && lo < u + 3) mon <= {mon[14:0], 1'b1};
      if (lk.line === 1'b1 && lo > 3 * u - 3 && lo < 3 * u + 3) mon <= {mon[14:0], 1'b0};
   end
   // ****
   // tasks
   // ****
   task automatic test_done;
      $display("checks %0d errors %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string nm);
      tests_run++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tick(inout int k);
      @(posedge clk);
      k++;
      if (k > 20000) begin
         chk(0, 1, "timeout");
         test_done();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
      int k;
      bit ad;
      bit dd;
      k = 0;
      ad = 1'b0;
      dd = 1'b0;
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      // each channel is let go only when its own ready is seen
      while (!(ad && dd)) begin
         tick(k);
         if (awr === 1'b1) begin
            ad = 1'b1;
            awv <= 1'b0;
         end
         if (wrd === 1'b1) begin
            dd = 1'b1;
            wv <= 1'b0;
         end
      end
      while (bv !== 1'b1) tick(k);
      chk(br, er, "bresp");
      bre <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [3:0] a);
      int k;
      k = 0;
      ara <= a;
      arv <= 1'b1;
      rre <= 1'b1;
      do tick(k); while (arr !== 1'b1);
      arv <= 1'b0;
      while (rv !== 1'b1) tick(k);
      s = rdd;
      sr = rr;
      rre <= 1'b0;
      @(posedge clk);
   endtask
   // open-drain host on the second link; bad marks an ambiguous bit
   task automatic bb(input logic [15:0] f, input int bad);
      for (int j = 15; j >= 0; j--) begin
         // line idles high here, so the address byte goes without start
         if (j == 7) begin
            lk2.host_oe_n <= 1'b1;
            repeat (40) @(posedge clk);
         end
         lk2.host_oe_n <= 1'b0;
         repeat (j == bad ? 32 : (f[j] ? 16 : 48)) @(posedge clk);
         lk2.host_oe_n <= 1'b1;
         repeat (j == bad ? 32 : (f[j] ? 48 : 16)) @(posedge clk);
         if (j % 8 == 0) begin
            lk2.host_oe_n <= 1'b0;
            repeat (j == 0 ? 104 : 40) @(posedge clk);
         end
      end
      lk2.host_oe_n <= 1'b1;
      repeat (2) @(posedge clk);
      ak = (lk2.line === 1'b0);
      n = 0;
      while (lk2.line !== 1'b1) tick(n);
   endtask
   initial begin
      lk2.host_do <= 1'b0;
      lk2.host_oe_n <= 1'b1;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(c1, opvs_pkg::SETTING_RST, "conv1 reset");
      rd(opvs_pkg::REG_UNIT);
      chk(s, opvs_pkg::UNIT_RST, "unit reset");
      rd(4'h2);
      chk(sr, opvs_pkg::RESP_SLVERR, "unmapped");
      $display("reset test done");
      n = 0;
      while (rdy !== 1'b1) tick(n);
      chk(n > opvs_pkg::STARTUP_CYC - 40, 1, "startup");
      wr(opvs_pkg::REG_MODE, 1, 0);
      n = 0;
      while (pwm !== 1'b1) tick(n);
      chk(n < 3, 1, "pwm on high");
      $display("mode test done");
      e1 = 5'h0;
      e2 = 5'h0;
      pz0 = pz;
      for (i = 0; i < 6; i++) begin
         if (i == 5) u = 24;
         if (i == 5) wr(opvs_pkg::REG_UNIT, 24, 0);
         d = fr[i];
         wr(opvs_pkg::REG_DATA, d, 0);
         if (i == 0) wr(opvs_pkg::REG_DATA, 0, opvs_pkg::RESP_SLVERR);
         n = 0;
         do begin
            rd(opvs_pkg::REG_STAT);
            tick(n);
         end while (s[0] !== 1'b0);
         if (d[6:5] == opvs_pkg::SEL_CONV1) e1 = d[4:0];
         if (d[6:5] == opvs_pkg::SEL_CONV2) e2 = d[4:0];
         chk(s[2:1], {1'b1, d[7]}, "status");
         chk(mon, {ADR, d}, "wire bits");
         chk(c1, e1, "conv1");
         chk(c2, e2, "conv2");
         chk(oks, i + 1, "frame ok");
         chk(pz, pz0, "pwm held");
      end
      $display("frame test done");
      wr(opvs_pkg::REG_MODE, 0, 0);
      n = 0;
      while (pwm !== 1'b0) tick(n);
      chk(n > TO - 10 && n < TO + 4, 1, "power save");
      $display("timeout test done");
      for (i = 0; i < 4; i++) begin
         if (i == 3) enb <= 1'b0;
         repeat (2) @(posedge clk);
         bb({i == 1 ? ~ADR : ADR, 8'(8'h8a + i)}, i == 2 ? 3 : -1);
         chk(ak, i == 0, "ack two");
         chk(c1b, 5'h0a, "conv1 two");
      end
      chk(rdy2, 0, "disabled");
      $display("fault test done");
      test_done();
   end
endmodule
